// ==== sncr_pkg.sv ====
// shared constants and types for the switch node configuration bank
package sncr_pkg;

   // register indices (word addresses on the configuration port)
   localparam logic [7:0] SNCR_IDX_IDENT     = 8'h00;
   localparam logic [7:0] SNCR_IDX_DESC      = 8'h01;
   localparam logic [7:0] SNCR_IDX_SWCFG     = 8'h04;
   localparam logic [7:0] SNCR_IDX_NODEID    = 8'h05;
   localparam logic [7:0] SNCR_IDX_PLL       = 8'h06;
   localparam logic [7:0] SNCR_IDX_SWDIV     = 8'h07;
   localparam logic [7:0] SNCR_IDX_REFDIV    = 8'h08;
   localparam logic [7:0] SNCR_IDX_JTAGID    = 8'h09;
   localparam logic [7:0] SNCR_IDX_USERCODE  = 8'h0A;
   localparam logic [7:0] SNCR_IDX_DIRLO     = 8'h0C;
   localparam logic [7:0] SNCR_IDX_DIRHI     = 8'h0D;

   // switch configuration field positions
   localparam int SNCR_CFG_CTLLOCK_BIT = 31;
   localparam int SNCR_CFG_PLLLOCK_BIT = 8;
   localparam int SNCR_CFG_HDR1_BIT    = 0;

   // pll settings field positions
   localparam int SNCR_PLL_NORST_BIT   = 31;
   localparam int SNCR_PLL_NOWAIT_BIT  = 30;
   localparam int SNCR_PLL_BYPASS_BIT  = 29;
   localparam int SNCR_PLL_JTAGBT_BIT  = 28;
   localparam int SNCR_PLL_P_LSB       = 23;
   localparam int SNCR_PLL_M_LSB       = 8;
   localparam int SNCR_PLL_N_LSB       = 0;

   // writable-bit masks; everything else is reserved or read-only
   localparam logic [31:0] SNCR_MASK_SWCFG  = 32'h8000_0101;
   localparam logic [31:0] SNCR_MASK_PLL    = 32'hF39F_FF7F;
   localparam logic [31:0] SNCR_MASK_LOW16  = 32'h0000_FFFF;

   // values after reset
   localparam logic [31:0] SNCR_RST_SWCFG   = 32'h0000_0000;
   localparam logic [15:0] SNCR_RST_NODEID  = 16'h0000;
   localparam logic [15:0] SNCR_RST_SWDIV   = 16'h0000;
   localparam logic [15:0] SNCR_RST_REFDIV  = 16'h0003;
   localparam logic [31:0] SNCR_RST_DIR     = 32'h0000_0000;
   localparam logic [31:0] SNCR_RST_PLL     = 32'h0000_0000;

   // length of the tile reset pulse raised by a pll settings write
   localparam logic [3:0] SNCR_TILE_RST_CYC = 4'h8;

   // configuration access request
   typedef struct packed {
      logic        wrEn;
      logic        rdEn;
      logic [7:0]  index;
      logic [31:0] wrData;
   } sncr_req_type;

   // routing decision
   typedef struct packed {
      logic       isLocal;
      logic [3:0] direction;
   } sncr_route_type;

endpackage : sncr_pkg

// ==== sncr_regs.sv ====
// configuration register bank and route lookup of the switch node
//
// Functional notes
// - identity word shows boot pins at 23:16, revision 15:8, version 7:0
// - description word shows link count, local and device processor counts
// - config bit 31 set blocks all writes to switch control registers
// - config bit 8 set blocks writes to pll control register
// - config bit 0 selects one-byte headers; resets to zero
// - node identifier is writable 16 bits, resets to zero
// - any pll settings write resets the tile unless suppressed
// - pll bit 31 applies new settings without chip reset
// - pll bit 30 skips waiting for pll re-lock
// - pll bit 29 places pll in bypass
// - pll bit 28 forces boot from jtag port
// - output divider p at 25:23, ratio minus one
// - feedback multiplier m at 20:8, ratio minus one
// - input divider n at 6:0, ratio minus one
// - switch clock divider is writable 16 bits, resets to zero
// - reference clock divider is writable 16 bits, resets to three
// - usercode word shows otp usercode 31:18 and metal id 17:0
// - low direction table: eight 4-bit fields, dimension 7 on top
// - route by most significant mismatching id bit; low table bits 7..0
// - high direction table serves mismatches in bits 15..8
// - high direction table: eight 4-bit fields, dimension 15 on top
module sncr_regs
   import sncr_pkg::*;
#(
   // arbitrary neutral identification values
   parameter logic [7:0]  SW_REVISION  = 8'h01,
   parameter logic [7:0]  SW_VERSION   = 8'h01,
   parameter logic [7:0]  NUM_LINKS    = 8'h08,
   parameter logic [7:0]  NUM_PROC_SW  = 8'h02,
   parameter logic [7:0]  NUM_PROC_DEV = 8'h02,
   parameter logic [31:0] JTAG_ID      = 32'h0000_0001,
   parameter logic [17:0] METAL_ID     = 18'h00001
) (
   input  wire logic           clk_sys,
   input  wire logic           srst,
   input  wire logic [7:0]     bootPins,
   input  wire logic [13:0]    otpUsercode,
   input  wire sncr_req_type   cfgReq,
   output logic [31:0]         cfgRdData,
   output logic                cfgRdValid,
   output logic                cfgWrRefused,
   input  wire logic [15:0]    pktDest,
   output sncr_route_type      route,
   output logic                headerOneByte,
   output logic [15:0]         nodeId,
   output logic [15:0]         switchClkDiv,
   output logic [15:0]         refClkDiv,
   output logic [2:0]          pllOutDiv,
   output logic [12:0]         pllMult,
   output logic [6:0]          pllInDiv,
   output logic                pllBypass,
   output logic                bootFromJtag,
   output logic                pllNoRelockWait,
   output logic                pllApply,
   output logic                tileReset
);

   //////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [7:0]  bootMeta_r;
   logic [7:0]  bootSync_r;
   logic [13:0] otpMeta_r;
   logic [13:0] otpSync_r;
   logic        bootCaptured_r;
   logic [7:0]  bootLatched_r;

   always_ff @(posedge clk_sys) begin
      bootMeta_r <= bootPins;
      bootSync_r <= bootMeta_r;
      otpMeta_r  <= otpUsercode;
      otpSync_r  <= otpMeta_r;
   end

   // boot pins are caught once after reset release, via the synchroniser
   // capture boot pins
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         bootCaptured_r <= 1'b0;
         bootLatched_r  <= 8'h00;
      end else if (!bootCaptured_r) begin
         bootCaptured_r <= 1'b1;
         bootLatched_r  <= bootSync_r;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // write decode

   logic [31:0] swCfg_r;
   logic [15:0] nodeId_r;
   logic [31:0] pll_r;
   logic [15:0] swDiv_r;
   logic [15:0] refDiv_r;
   logic [31:0] dirLo_r;
   logic [31:0] dirHi_r;
   logic        ctlLocked;
   logic        pllLocked;
   logic        wrOk;
   logic        pllWrOk;

   assign ctlLocked = swCfg_r[SNCR_CFG_CTLLOCK_BIT];
   assign pllLocked = swCfg_r[SNCR_CFG_PLLLOCK_BIT];
   assign wrOk      = cfgReq.wrEn && !ctlLocked;
   assign pllWrOk   = wrOk && !pllLocked
                      && (cfgReq.index == SNCR_IDX_PLL);

   function automatic logic isWritable(input logic [7:0] idx);
      return idx == SNCR_IDX_SWCFG || idx == SNCR_IDX_NODEID
          || idx == SNCR_IDX_PLL   || idx == SNCR_IDX_SWDIV
          || idx == SNCR_IDX_REFDIV || idx == SNCR_IDX_DIRLO
          || idx == SNCR_IDX_DIRHI;
   endfunction : isWritable

   // refusal strobe: locked bank or locked pll register
   // report refused writes
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cfgWrRefused <= 1'b0;
      end else begin
         cfgWrRefused <= cfgReq.wrEn && isWritable(cfgReq.index)
            && (ctlLocked
                || (pllLocked && cfgReq.index == SNCR_IDX_PLL));
      end
   end

   // header mode and locks live here
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         swCfg_r <= SNCR_RST_SWCFG;
      end else if (wrOk && cfgReq.index == SNCR_IDX_SWCFG) begin
         swCfg_r <= cfgReq.wrData & SNCR_MASK_SWCFG;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         nodeId_r <= SNCR_RST_NODEID;
      end else if (wrOk && cfgReq.index == SNCR_IDX_NODEID) begin
         nodeId_r <= cfgReq.wrData[15:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pll_r <= SNCR_RST_PLL;
      end else if (pllWrOk) begin
         pll_r <= cfgReq.wrData & SNCR_MASK_PLL;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         swDiv_r <= SNCR_RST_SWDIV;
      end else if (wrOk && cfgReq.index == SNCR_IDX_SWDIV) begin
         swDiv_r <= cfgReq.wrData[15:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         refDiv_r <= SNCR_RST_REFDIV;
      end else if (wrOk && cfgReq.index == SNCR_IDX_REFDIV) begin
         refDiv_r <= cfgReq.wrData[15:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         dirLo_r <= SNCR_RST_DIR;
         dirHi_r <= SNCR_RST_DIR;
      end else if (wrOk) begin
         if (cfgReq.index == SNCR_IDX_DIRLO) begin
            dirLo_r <= cfgReq.wrData;
         end
         if (cfgReq.index == SNCR_IDX_DIRHI) begin
            dirHi_r <= cfgReq.wrData;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // pll write side effects

   logic [3:0] tileRstCnt_r;
   logic       tileRstLoad;
   assign tileRstLoad = pllWrOk && !cfgReq.wrData[SNCR_PLL_NORST_BIT];

   // settings reach the pll on a one-cycle apply strobe
   // apply without reset when bit 31 is set
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pllApply <= 1'b0;
      end else begin
         pllApply <= pllWrOk;
      end
   end

   // a fixed pulse length keeps the tile held across the pll update;
   // the output is a flop so a counter decode cannot glitch the reset
   // tile reset on pll write
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         tileRstCnt_r <= 4'h0;
         tileReset    <= 1'b0;
      end else begin
         tileReset <= tileRstLoad || (tileRstCnt_r > 4'h1);
         if (tileRstLoad) begin
            tileRstCnt_r <= SNCR_TILE_RST_CYC;
         end else if (tileRstCnt_r != 4'h0) begin
            tileRstCnt_r <= tileRstCnt_r - 4'h1;
         end
      end
   end

   assign pllNoRelockWait = pll_r[SNCR_PLL_NOWAIT_BIT];
   assign pllBypass       = pll_r[SNCR_PLL_BYPASS_BIT];
   assign bootFromJtag    = pll_r[SNCR_PLL_JTAGBT_BIT];
   assign pllOutDiv       = pll_r[SNCR_PLL_P_LSB +: 3];
   assign pllMult         = pll_r[SNCR_PLL_M_LSB +: 13];
   assign pllInDiv        = pll_r[SNCR_PLL_N_LSB +: 7];
   assign headerOneByte   = swCfg_r[SNCR_CFG_HDR1_BIT];
   assign nodeId          = nodeId_r;
   assign switchClkDiv    = swDiv_r;
   assign refClkDiv       = refDiv_r;

   //////////////////////////////////////////////////////////////////////////
   // read path

   logic [31:0] rdMux;

   // reserved bits and unmapped indices read zero
   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (cfgReq.index)
         SNCR_IDX_IDENT:
            rdMux = {8'h00, bootLatched_r, SW_REVISION, SW_VERSION};
         SNCR_IDX_DESC:
            rdMux = {8'h00, NUM_LINKS, NUM_PROC_SW, NUM_PROC_DEV};
         SNCR_IDX_SWCFG:    rdMux = swCfg_r;
         SNCR_IDX_NODEID:   rdMux = {16'h0000, nodeId_r};
         SNCR_IDX_PLL:      rdMux = pll_r;
         SNCR_IDX_SWDIV:    rdMux = {16'h0000, swDiv_r};
         SNCR_IDX_REFDIV:   rdMux = {16'h0000, refDiv_r};
         SNCR_IDX_JTAGID:   rdMux = JTAG_ID;
         SNCR_IDX_USERCODE: rdMux = {otpSync_r, METAL_ID};
         SNCR_IDX_DIRLO:    rdMux = dirLo_r;
         SNCR_IDX_DIRHI:    rdMux = dirHi_r;
         default:           rdMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cfgRdData  <= 32'h0000_0000;
         cfgRdValid <= 1'b0;
      end else begin
         cfgRdValid <= cfgReq.rdEn;
         if (cfgReq.rdEn) begin
            cfgRdData <= rdMux;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // route lookup

   function automatic logic [3:0] topBit(input logic [15:0] diff);
      logic [3:0] pos;
      pos = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (diff[i]) begin
            pos = 4'(i);
         end
      end
      return pos;
   endfunction : topBit

   logic [15:0]    idDiff;
   logic [3:0]     dim;
   sncr_route_type routeNxt;

   assign idDiff = pktDest ^ nodeId_r;
   assign dim    = topBit(idDiff);

   // most significant mismatch selects low or high table entry
   always_comb begin
      routeNxt.isLocal   = (idDiff == 16'h0000);
      routeNxt.direction = 4'h0;
      if (!routeNxt.isLocal) begin
         if (dim[3]) begin
            routeNxt.direction = dirHi_r[{dim[2:0], 2'b00} +: 4];
         end else begin
            routeNxt.direction = dirLo_r[{dim[2:0], 2'b00} +: 4];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         route <= '0;
      end else begin
         route <= routeNxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // checks

   sequence pllWrSeq;
      tileRstLoad;
   endsequence

   sequence rstQuietSeq;
      !tileRstLoad [*8];
   endsequence

   chk_ctl_lock_hold: assert property (
      @(posedge clk_sys) disable iff (srst)
      ctlLocked && cfgReq.wrEn |=> $stable(swCfg_r) && $stable(nodeId_r)
         && $stable(pll_r) && $stable(swDiv_r) && $stable(refDiv_r)
         && $stable(dirLo_r) && $stable(dirHi_r))
      else $error("write taken while control lock set");

   chk_pll_lock_hold: assert property (
      @(posedge clk_sys) disable iff (srst)
      pllLocked |=> $stable(pll_r))
      else $error("pll written while pll lock set");

   chk_hdr_reset: assert property (
      @(posedge clk_sys) disable iff (srst)
      $past(srst) |-> !headerOneByte && refClkDiv == SNCR_RST_REFDIV)
      else $error("header or ref divider wrong after reset");

   chk_tile_rst_len: assert property (
      @(posedge clk_sys) disable iff (srst)
      pllWrSeq |=> tileReset [*8])
      else $error("tile reset pulse too short");

   chk_tile_rst_end: assert property (
      @(posedge clk_sys) disable iff (srst)
      pllWrSeq ##1 rstQuietSeq |=> !tileReset)
      else $error("tile reset pulse too long");

   chk_norst_write: assert property (
      @(posedge clk_sys) disable iff (srst)
      pllWrOk && cfgReq.wrData[SNCR_PLL_NORST_BIT] && !tileReset
      |=> pllApply && !tileReset)
      else $error("no-reset pll write reset the tile");

   chk_route_local: assert property (
      @(posedge clk_sys) disable iff (srst)
      pktDest == nodeId_r |=> route.isLocal)
      else $error("matching destination not local");

   chk_route_high: assert property (
      @(posedge clk_sys) disable iff (srst)
      idDiff[15] |=> route.direction == $past(dirHi_r[31:28]))
      else $error("bit 15 mismatch used wrong direction");

   chk_route_low: assert property (
      @(posedge clk_sys) disable iff (srst)
      idDiff == 16'h0001 |=> route.direction == $past(dirLo_r[3:0]))
      else $error("bit 0 mismatch used wrong direction");

   chk_rsv_zero: assert property (
      @(posedge clk_sys) disable iff (srst)
      cfgRdValid |-> !(cfgRdData[31:16] != 16'h0000
         && $past(cfgReq.index) == SNCR_IDX_NODEID))
      else $error("reserved node id bits read nonzero");

endmodule : sncr_regs

// ==== sncr_regs_tb.sv ====
// self-checking testbench for the switch node configuration bank
module testbench
   import sncr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic           clk_sys;
   logic           srst;
   logic [7:0]     bootPins;
   logic [13:0]    otpUsercode;
   sncr_req_type   cfgReq;
   logic [31:0]    cfgRdData;
   logic           cfgRdValid;
   logic           cfgWrRefused;
   logic [15:0]    pktDest;
   sncr_route_type route;
   logic           headerOneByte;
   logic [15:0]    nodeId;
   logic [15:0]    switchClkDiv;
   logic [15:0]    refClkDiv;
   logic [2:0]     pllOutDiv;
   logic [12:0]    pllMult;
   logic [6:0]     pllInDiv;
   logic           pllBypass;
   logic           bootFromJtag;
   logic           pllNoRelockWait;
   logic           pllApply;
   logic           tileReset;
   int             error_cnt;
   int             checks_done;

   sncr_regs sncr_regs_inst (
      .clk_sys(clk_sys), .srst(srst), .bootPins(bootPins),
      .otpUsercode(otpUsercode), .cfgReq(cfgReq), .cfgRdData(cfgRdData),
      .cfgRdValid(cfgRdValid), .cfgWrRefused(cfgWrRefused),
      .pktDest(pktDest), .route(route), .headerOneByte(headerOneByte),
      .nodeId(nodeId), .switchClkDiv(switchClkDiv), .refClkDiv(refClkDiv),
      .pllOutDiv(pllOutDiv), .pllMult(pllMult), .pllInDiv(pllInDiv),
      .pllBypass(pllBypass), .bootFromJtag(bootFromJtag),
      .pllNoRelockWait(pllNoRelockWait), .pllApply(pllApply),
      .tileReset(tileReset)
   );

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // all stimulus moves 1 ns after the rising edge
   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask : tick

   // the leading tick keeps two requests out of one time step
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      tick();
      cfgReq = '{wrEn: 1'b1, rdEn: 1'b0, index: idx, wrData: d};
      tick();
      cfgReq = '0;
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
      tick();
      cfgReq = '{wrEn: 1'b0, rdEn: 1'b1, index: idx, wrData: 32'h0};
      tick();
      cfgReq = '0;
      check(32'(cfgRdValid), 32'h1);
      check(cfgRdData, exp);
   endtask : rd

   task automatic reset_dut();
      srst = 1'b1;
      repeat (16) tick();
      srst = 1'b0;
   endtask : reset_dut

   ////////////////////////////////////////////////////////////////////////
   task automatic test_reset_values();
      logic [7:0]  ix [12] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h07,
                               8'h08, 8'h09, 8'h0A, 8'h0C, 8'h0D, 8'h0B};
      logic [31:0] ex [12] = '{32'h00A5_0101, 32'h0008_0202, 32'h0, 32'h0,
                               32'h0, 32'h0, 32'h3, 32'h0000_0001,
                               32'h0AAC_0001, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 12; i++) begin
         rd(ix[i], ex[i]);
      end
      check(32'(refClkDiv), 32'h3);
      check(32'({tileReset, headerOneByte, nodeId}), 32'h0);
      $display("reset values done");
   endtask : test_reset_values

   task automatic test_writes();
      wr(SNCR_IDX_NODEID, 32'hFFFF_1234);
      rd(SNCR_IDX_NODEID, 32'h0000_1234);
      check(32'(nodeId), 32'h1234);
      wr(SNCR_IDX_SWDIV, 32'hABCD_8001);
      rd(SNCR_IDX_SWDIV, 32'h0000_8001);
      check(32'(switchClkDiv), 32'h8001);
      wr(SNCR_IDX_REFDIV, 32'h0001_FFFE);
      rd(SNCR_IDX_REFDIV, 32'h0000_FFFE);
      check(32'(refClkDiv), 32'hFFFE);
      wr(SNCR_IDX_DIRLO, 32'h7654_3210);
      wr(SNCR_IDX_DIRHI, 32'hFEDC_BA98);
      rd(SNCR_IDX_DIRLO, 32'h7654_3210);
      rd(SNCR_IDX_DIRHI, 32'hFEDC_BA98);
      wr(SNCR_IDX_IDENT, 32'hFFFF_FFFF);
      check(32'(cfgWrRefused), 32'h0);
      rd(SNCR_IDX_IDENT, 32'h00A5_0101);
      wr(SNCR_IDX_USERCODE, 32'h0);
      rd(SNCR_IDX_USERCODE, 32'h0AAC_0001);
      wr(SNCR_IDX_SWCFG, 32'h7FFF_FEFE);
      rd(SNCR_IDX_SWCFG, 32'h0);
      $display("register writes done");
   endtask : test_writes

   task automatic test_route();
      for (int d = 0; d < 16; d++) begin
         // lower bits flipped too, so only the top mismatch may decide
         pktDest = 16'h1234 ^ 16'((2 << d) - 1);
         tick();
         check(32'(route), 32'(d));
      end
      pktDest = 16'h1234;
      tick();
      check(32'(route), 32'h10);
      $display("route lookup done");
   endtask : test_route

   task automatic test_pll();
      wr(SNCR_IDX_PLL, 32'h7FFF_FFFF);
      check(32'(pllApply), 32'h1);
      for (int i = 0; i < 8; i++) begin
         check(32'(tileReset), 32'h1);
         tick();
      end
      check(32'({pllApply, tileReset}), 32'h0);
      check(32'({pllNoRelockWait, pllBypass, bootFromJtag, pllOutDiv, pllMult,
             pllInDiv}), 32'h03FF_FFFF);
      rd(SNCR_IDX_PLL, 32'h739F_FF7F);
      wr(SNCR_IDX_PLL, 32'h8080_0A03);
      check(32'({pllApply, tileReset}), 32'h2);
      tick();
      check(32'(tileReset), 32'h0);
      check(32'({pllNoRelockWait, pllBypass, bootFromJtag, pllOutDiv, pllMult,
             pllInDiv}), 32'h0010_0503);
      $display("pll settings done");
   endtask : test_pll

   task automatic test_locks();
      wr(SNCR_IDX_SWCFG, 32'h0000_0101);
      check(32'(headerOneByte), 32'h1);
      rd(SNCR_IDX_SWCFG, 32'h0000_0101);
      wr(SNCR_IDX_PLL, 32'h0);
      check(32'({cfgWrRefused, pllApply, tileReset}), 32'h4);
      rd(SNCR_IDX_PLL, 32'h8080_0A03);
      wr(SNCR_IDX_SWCFG, 32'h8000_0001);
      check(32'(cfgWrRefused), 32'h0);
      wr(SNCR_IDX_NODEID, 32'h0000_5555);
      check(32'(cfgWrRefused), 32'h1);
      rd(SNCR_IDX_NODEID, 32'h0000_1234);
      wr(SNCR_IDX_SWCFG, 32'h0);
      rd(SNCR_IDX_SWCFG, 32'h8000_0001);
      // boot pins change just before reset and are caught again after its release
      bootPins = 8'h3C;
      reset_dut();
      rd(SNCR_IDX_SWCFG, 32'h0);
      rd(SNCR_IDX_IDENT, 32'h003C_0101);
      wr(SNCR_IDX_NODEID, 32'h0000_00FF);
      rd(SNCR_IDX_NODEID, 32'h0000_00FF);
      $display("write locks done");
   endtask : test_locks

   ////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out

   // a hang is cut short and counted as a mismatch
   initial begin
      repeat (5000) @(posedge clk_sys);
      error_cnt++;
      close_out();
   end

   initial begin
      error_cnt = 0;
      checks_done = 0;
      srst = 1'b1;
      bootPins = 8'hA5;
      otpUsercode = 14'h2AB;
      cfgReq = '0;
      pktDest = 16'h0;
      reset_dut();
      test_reset_values();
      test_writes();
      test_route();
      test_pll();
      test_locks();
      close_out();
   end

endmodule : testbench
